// file: rfc_map.svh
// Purpose: Register offsets, field positions and reset values for region_fail_capture
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   Included by the package and the design modules
`ifndef RFC_MAP_SVH
`define RFC_MAP_SVH

`define RFC_NUM_FILTERS      2
`define RFC_NUM_REGIONS      8
`define RFC_TAG_WIDTH        8
`define RFC_VNET_WIDTH       4

// Register byte offsets
`define RFC_OFF_INT_STATUS   12'h000
`define RFC_OFF_INT_MASK     12'h004
`define RFC_OFF_INT_CLEAR    12'h008
`define RFC_OFF_FAIL_ID0     12'h010
`define RFC_OFF_BASE_LOW0    12'h100

// Field positions
`define RFC_VNET_LSB         24
`define RFC_VNET_MSB         27
`define RFC_BASE_LSB         12
`define RFC_BASE_MSB         31

// Reset values
`define RFC_BASE_RESET       20'h00000
`define RFC_STATUS_RESET     2'h0
`define RFC_MASK_RESET       2'h0

`endif

// file: rfc_pkg.sv
// Purpose: Shared types for region_fail_capture
// Assumes: rfc_map.svh sets the widths
// Notes:   Types only; numbers live in the map header
`include "rfc_map.svh"

package rfc_pkg;
    typedef logic [`RFC_TAG_WIDTH-1:0]   rfc_tag_type;
    typedef logic [`RFC_VNET_WIDTH-1:0]  rfc_vnet_type;
    typedef logic [`RFC_NUM_FILTERS-1:0] rfc_fvec_type;
    typedef logic [19:0]                 rfc_base_type;
endpackage

// file: rfc_fail_if.sv
// Purpose: Failure report from the main block into one capture unit
// Assumes: Single clock domain
// Notes:   Carries the event, its tag and its virtual network
`timescale 1ns/1ps

interface rfc_fail_if;
    import rfc_pkg::*;
    logic         fail;
    logic         is_write;
    rfc_tag_type  rd_tag;
    rfc_tag_type  wr_tag;
    rfc_vnet_type rd_vnet;
    rfc_vnet_type wr_vnet;
    logic         clear;
    logic         flag;
    logic [31:0]  ident;
    modport src (output fail, is_write, rd_tag, wr_tag, rd_vnet, wr_vnet, clear,
                 input flag, ident);
    modport dst (input fail, is_write, rd_tag, wr_tag, rd_vnet, wr_vnet, clear,
                 output flag, ident);
endinterface

// file: rfc_capture.sv
// Purpose: First-failure capture for one filter unit
// Assumes: Synchronous active-low reset
// Notes:   Status flag freezes the record until cleared
`timescale 1ns/1ps
`include "rfc_map.svh"

module rfc_capture (
    input  wire logic clk_i,
    input  wire logic nrst_i,
    rfc_fail_if.dst   fi
);
    import rfc_pkg::*;

    logic         flag_r;
    rfc_tag_type  tag_r;
    rfc_vnet_type vnet_r;

    // Flag: new failure wins over a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            flag_r <= 1'b0;
        end else if (fi.fail) begin
            flag_r <= 1'b1;
        end else if (fi.clear) begin
            flag_r <= 1'b0;
        end
    end

    // Record only when flag clear or a clear arrives in the same cycle, so the first one sticks
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            tag_r  <= '0;
            vnet_r <= '0;
        end else if (fi.fail && (!flag_r || fi.clear)) begin
            tag_r  <= fi.is_write ? fi.wr_tag : fi.rd_tag;
            vnet_r <= fi.is_write ? fi.wr_vnet : fi.rd_vnet;
        end
    end

    assign fi.flag  = flag_r;
    // Reserved bits read zero
    always_comb begin
        fi.ident = 32'h00000000;
        fi.ident[`RFC_TAG_WIDTH-1:0] = tag_r;
        fi.ident[`RFC_VNET_MSB:`RFC_VNET_LSB] = vnet_r;
    end

    a_frozen_record: assert property (@(posedge clk_i) disable iff (!nrst_i)
        flag_r && !fi.clear |=> $stable(tag_r) && $stable(vnet_r))
        else $error("capture changed while flag set");
    a_first_capture: assert property (@(posedge clk_i) disable iff (!nrst_i)
        fi.fail && !flag_r && !fi.is_write |=> tag_r == $past(fi.rd_tag))
        else $error("read tag not captured");
    a_write_vnet: assert property (@(posedge clk_i) disable iff (!nrst_i)
        fi.fail && !flag_r && fi.is_write |=> vnet_r == $past(fi.wr_vnet))
        else $error("write vnet not captured");
    a_flag_sets: assert property (@(posedge clk_i) disable iff (!nrst_i)
        fi.fail |=> flag_r)
        else $error("flag not set on failure");
endmodule // rfc_capture

// file: rfc_region_fail_capture.sv
// Purpose: Failure-ID capture and region base-low registers over APB
// Assumes: 40 MHz clk_i, synchronous active-low nrst_i, APB master
// Notes:   Permission and overlap detection arrive as pulse inputs
`timescale 1ns/1ps
`include "rfc_map.svh"

module rfc_region_fail_capture (
    input  wire logic                    clk_i,
    input  wire logic                    nrst_i,
    input  wire logic                    psel_i,
    input  wire logic                    penable_i,
    input  wire logic                    pwrite_i,
    input  wire logic [11:0]             paddr_i,
    input  wire logic [31:0]             pwdata_i,
    output logic      [31:0]             prdata_o,
    output logic                         pready_o,
    output logic                         pslverr_o,
    input  wire rfc_pkg::rfc_fvec_type   fail_i,
    input  wire rfc_pkg::rfc_fvec_type   fail_is_write_i,
    input  wire logic [`RFC_NUM_FILTERS*`RFC_TAG_WIDTH-1:0]  read_tag_in_i,
    input  wire logic [`RFC_NUM_FILTERS*`RFC_TAG_WIDTH-1:0]  write_tag_in_i,
    input  wire logic [`RFC_NUM_FILTERS*`RFC_VNET_WIDTH-1:0] read_virtual_network_in_i,
    input  wire logic [`RFC_NUM_FILTERS*`RFC_VNET_WIDTH-1:0] write_virtual_network_in_i,
    output logic [`RFC_NUM_REGIONS*32-1:0] region_base_o,
    output logic                         irq_o
);
    import rfc_pkg::*;

    rfc_base_type base_r [`RFC_NUM_REGIONS];
    rfc_fvec_type mask_r;
    rfc_fvec_type flag_w;
    rfc_fvec_type clear_w;
    logic [31:0]  ident_w [`RFC_NUM_FILTERS];
    logic [31:0]  rdata_nxt;
    logic         err_nxt;
    logic         wr_go;

    // Word index within the base-low bank, or -1 when outside it or not word-aligned
    function automatic int base_index(input logic [11:0] a);
        int off;
        off = int'(a) - int'(`RFC_OFF_BASE_LOW0);
        if (off >= 0 && off < 4 * `RFC_NUM_REGIONS && off[1:0] == 2'b00) begin
            return off / 4;
        end
        return -1;
    endfunction

    function automatic int fail_index(input logic [11:0] a);
        int off;
        off = int'(a) - int'(`RFC_OFF_FAIL_ID0);
        if (off >= 0 && off < 4 * `RFC_NUM_FILTERS && off[1:0] == 2'b00) begin
            return off / 4;
        end
        return -1;
    endfunction

    // Zero-wait slave: access phase answers at once
    assign pready_o = 1'b1;
    assign wr_go    = psel_i && penable_i && pwrite_i;

    // One capture unit per filter
    genvar g;
    generate
        for (g = 0; g < `RFC_NUM_FILTERS; g++) begin : g_cap
            rfc_fail_if fif ();
            assign fif.fail     = fail_i[g];
            assign fif.is_write = fail_is_write_i[g];
            assign fif.rd_tag   = read_tag_in_i[g*`RFC_TAG_WIDTH +: `RFC_TAG_WIDTH];
            assign fif.wr_tag   = write_tag_in_i[g*`RFC_TAG_WIDTH +: `RFC_TAG_WIDTH];
            assign fif.rd_vnet  = read_virtual_network_in_i[g*`RFC_VNET_WIDTH +: `RFC_VNET_WIDTH];
            assign fif.wr_vnet  = write_virtual_network_in_i[g*`RFC_VNET_WIDTH +: `RFC_VNET_WIDTH];
            assign fif.clear    = clear_w[g];
            assign flag_w[g]    = fif.flag;
            assign ident_w[g]   = fif.ident;
            rfc_capture u_cap (
                .clk_i  (clk_i),
                .nrst_i (nrst_i),
                .fi     (fif.dst)
            );
        end
    endgenerate

    // Write-one-to-clear through the clear register
    assign clear_w = (wr_go && paddr_i == `RFC_OFF_INT_CLEAR)
                   ? pwdata_i[`RFC_NUM_FILTERS-1:0] : '0;

    // Mask register
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            mask_r <= `RFC_MASK_RESET;
        end else if (wr_go && paddr_i == `RFC_OFF_INT_MASK) begin
            mask_r <= pwdata_i[`RFC_NUM_FILTERS-1:0];
        end
    end

    // Base-low bank; region 0 never written
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < `RFC_NUM_REGIONS; i++) begin
                base_r[i] <= `RFC_BASE_RESET;
            end
        end else if (wr_go && base_index(paddr_i) > 0) begin
            base_r[base_index(paddr_i)] <= pwdata_i[`RFC_BASE_MSB:`RFC_BASE_LSB];
        end
    end

    // Base addresses for the filters; low bits forced zero
    always_comb begin
        region_base_o = '0;
        for (int i = 1; i < `RFC_NUM_REGIONS; i++) begin
            region_base_o[i*32 +: 32] = {base_r[i], 12'h000};
        end
    end

    // Read mux; unmapped addresses answer with an error
    always_comb begin
        int bi;
        int fi;
        bi = base_index(paddr_i);
        fi = fail_index(paddr_i);
        rdata_nxt = 32'h00000000;
        err_nxt   = 1'b0;
        if (paddr_i == `RFC_OFF_INT_STATUS) begin
            rdata_nxt[`RFC_NUM_FILTERS-1:0] = flag_w;
        end else if (paddr_i == `RFC_OFF_INT_MASK) begin
            rdata_nxt[`RFC_NUM_FILTERS-1:0] = mask_r;
        end else if (paddr_i == `RFC_OFF_INT_CLEAR) begin
            rdata_nxt = 32'h00000000;
        end else if (fi >= 0) begin
            rdata_nxt = ident_w[fi];
        end else if (bi == 0) begin
            rdata_nxt = 32'h00000000;
        end else if (bi > 0) begin
            rdata_nxt = {base_r[bi], 12'h000};
        end else begin
            err_nxt = 1'b1;
        end
    end

    assign prdata_o  = (psel_i && penable_i && !pwrite_i) ? rdata_nxt : 32'h00000000;
    assign pslverr_o = psel_i && penable_i && err_nxt;
    assign irq_o     = |(flag_w & mask_r);

    a_region0_zero: assert property (@(posedge clk_i) disable iff (!nrst_i)
        base_r[0] == 20'h00000)
        else $error("region 0 base not zero");
    a_base_write: assert property (@(posedge clk_i) disable iff (!nrst_i)
        wr_go && paddr_i == `RFC_OFF_BASE_LOW0 + 12'h004
        |=> base_r[1] == $past(pwdata_i[31:12]))
        else $error("base write lost");
    a_low_zero: assert property (@(posedge clk_i) disable iff (!nrst_i)
        region_base_o[43:32] == 12'h000)
        else $error("base low bits not zero");
    a_clear_flag: assert property (@(posedge clk_i) disable iff (!nrst_i)
        clear_w[0] && !fail_i[0] |=> !flag_w[0])
        else $error("clear did not drop flag");

    // Interrupt is a plain level of the unmasked flags
    a_irq_level: assert property (@(posedge clk_i) disable iff (!nrst_i)
        irq_o == |(flag_w & mask_r))
        else $error("irq level wrong");

    // Unmapped addresses must be refused in the access phase
    a_unmapped_err: assert property (@(posedge clk_i) disable iff (!nrst_i)
        psel_i && penable_i && paddr_i == 12'h0FC |-> pslverr_o)
        else $error("unmapped access not refused");

    // Failure record of filter 1 reads back tag and vnet fields only
    a_ident_reserved: assert property (@(posedge clk_i) disable iff (!nrst_i)
        ident_w[1][31:28] == 4'h0 && ident_w[1][23:`RFC_TAG_WIDTH] == 16'h0000)
        else $error("reserved ident bits set");
endmodule // rfc_region_fail_capture

// file: rfc_fail_src.sv
// Purpose: Model of the bus masters whose accesses fail a region check
// Assumes: One clock; a failure is a one-cycle pulse sampled at the DUT edge
// Notes:   Lines for the other direction carry inverted values to expose mix-ups
`timescale 1ns/1ps

module rfc_fail_src (
    input  wire logic        clk_i,
    output logic      [1:0]  fail_o,
    output logic      [1:0]  wr_o,
    output logic      [15:0] rtag_o,
    output logic      [15:0] wtag_o,
    output logic      [7:0]  rvn_o,
    output logic      [7:0]  wvn_o
);
    initial begin
        fail_o = 2'h0;
        wr_o   = 2'h0;
        rtag_o = 16'h0000;
        wtag_o = 16'h0000;
        rvn_o  = 8'h00;
        wvn_o  = 8'h00;
    end

    // One failing access on filter f; after it the tags flip so stale data never matches
    task automatic hit(input int f, input logic w, input logic [7:0] t, input logic [3:0] v);
        @(posedge clk_i);
        fail_o    <= 2'(2'h1 << f);
        wr_o      <= {2{w}};
        rtag_o    <= {2{w ? ~t : t}};
        wtag_o    <= {2{w ? t : ~t}};
        rvn_o     <= {2{w ? ~v : v}};
        wvn_o     <= {2{w ? v : ~v}};
        @(posedge clk_i);
        fail_o    <= 2'h0;
        rtag_o    <= ~rtag_o;
        wtag_o    <= ~wtag_o;
        rvn_o     <= ~rvn_o;
        wvn_o     <= ~wvn_o;
    endtask
endmodule // rfc_fail_src

// file: rfc_region_fail_capture_test.sv
// Purpose: Self-checking bench for the failure capture and base-low registers
// Assumes: APB with zero wait states expected but not relied on
// Notes:   Directed scenarios only, one task each
`timescale 1ns/1ps
`include "rfc_map.svh"

module region_fail_capture_test;
    logic clk_i = 1'b0, nrst_i = 1'b0;
    logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0, prdata_o;
    logic pready_o, pslverr_o, irq_o;
    logic [1:0] fail_i, fail_is_write_i;
    logic [15:0] rtag, wtag;
    logic [7:0] rvn, wvn;
    logic [255:0] region_base_o;
    int fails = 0, checks = 0;

    rfc_fail_src i_src (.clk_i(clk_i), .fail_o(fail_i), .wr_o(fail_is_write_i),
        .rtag_o(rtag), .wtag_o(wtag), .rvn_o(rvn), .wvn_o(wvn));
    rfc_region_fail_capture i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .fail_i(fail_i), .fail_is_write_i(fail_is_write_i), .read_tag_in_i(rtag),
        .write_tag_in_i(wtag), .read_virtual_network_in_i(rvn),
        .write_virtual_network_in_i(wvn), .region_base_o(region_base_o), .irq_o(irq_o));

    // 25 ns clock
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        checks++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e);
        end
    endtask

    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge clk_i);
        psel_i <= 1'b1; penable_i <= 1'b0; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 50);
        if (pready_o !== 1'b1) begin
            fails++;
            $display("CHECK FAILED t=%0t apb wait limit", $time);
        end
        r = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0; penable_i <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r; logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] x, input string m);
        logic [31:0] r; logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, x, m);
    endtask

    // First failure kept, later ones ignored until cleared, direction picks the inputs
    task automatic t_capture;
        i_src.hit(0, 1'b0, 8'hA5, 4'h9);
        rd(`RFC_OFF_FAIL_ID0, 32'h0900_00A5, "read fail id");
        i_src.hit(0, 1'b1, 8'h3C, 4'h6);
        rd(`RFC_OFF_FAIL_ID0, 32'h0900_00A5, "frozen id");
        i_src.hit(1, 1'b1, 8'h3C, 4'h6);
        rd(`RFC_OFF_FAIL_ID0 + 12'h004, 32'h0600_003C, "write fail id");
        rd(`RFC_OFF_INT_STATUS, 32'h3, "status both");
        chk({31'h0, irq_o}, 32'h0, "masked irq");
        wr(`RFC_OFF_INT_CLEAR, 32'h1);
        rd(`RFC_OFF_INT_STATUS, 32'h2, "status cleared");
        i_src.hit(0, 1'b1, 8'h5A, 4'h2);
        rd(`RFC_OFF_FAIL_ID0, 32'h0200_005A, "id after clear");
    endtask

    // Level interrupt follows status and mask
    task automatic t_irq;
        // Registers settle after the write edge, so look half a cycle later
        wr(`RFC_OFF_INT_MASK, 32'h1);
        @(negedge clk_i);
        chk({31'h0, irq_o}, 32'h1, "irq on");
        wr(`RFC_OFF_INT_CLEAR, 32'h3);
        @(negedge clk_i);
        chk({31'h0, irq_o}, 32'h0, "irq off");
        rd(`RFC_OFF_INT_STATUS, 32'h0, "status zero");
    endtask

    // Base-low fields, region 0 fixed at zero, unmapped address refused
    task automatic t_base;
        logic [31:0] r; logic e;
        wr(`RFC_OFF_BASE_LOW0 + 12'h00C, 32'hFFFF_FFFF);
        rd(`RFC_OFF_BASE_LOW0 + 12'h00C, 32'hFFFF_F000, "base low3");
        chk(region_base_o[96 +: 32], 32'hFFFF_F000, "base out3");
        wr(`RFC_OFF_BASE_LOW0, 32'h1234_5000);
        rd(`RFC_OFF_BASE_LOW0, 32'h0, "base low0");
        chk(region_base_o[31:0], 32'h0, "base out0");
        apb(1'b0, 12'h0FC, 32'h0, r, e);
        chk({31'h0, e}, 32'h1, "unmapped err");
    endtask

    task automatic end_of_test;
        $display("fails=%0d checks=%0d", fails, checks);
        if (fails == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge clk_i);
        nrst_i <= 1'b1;
        rd(`RFC_OFF_FAIL_ID0, 32'h0, "reset id");
        t_capture;
        t_irq;
        t_base;
        end_of_test;
    end

    // Hang guard
    initial begin
        repeat (5000) @(posedge clk_i);
        fails++;
        end_of_test;
    end
endmodule // region_fail_capture_test
